//--- hdl/flash_sec.sv
// flash_sec: flash security state, backdoor key unlock and debug blank-check unlock behind an AXI4-Lite slave.
// assumes the nonvolatile image is stable around reset release and the origin sideband is valid with awvalid.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_map.svh"

module flash_sec
  import flash_sec_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // nonvolatile image and flash state
  input  wire nv_image_t    nv_i,
  input  wire logic         flash_blank_i,
  // bus origin sideband, valid with awvalid_i
  input  wire bus_origin_t  origin_i,
  // debug memory access path
  input  wire dbg_mem_req_t dbg_mem_i,
  output logic              dbg_mem_grant_o,
  // security outputs
  output logic              secured_o,
  output logic              debug_module_en_o,
  output logic              key_block_locked_o,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic [2:0]   awprot_i,
  input  wire logic         awvalid_i,
  output logic              awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]  wdata_i,
  input  wire logic [3:0]   wstrb_i,
  input  wire logic         wvalid_i,
  output logic              wready_o,
  // AXI4-Lite write response
  output logic [1:0]        bresp_o,
  output logic              bvalid_o,
  input  wire logic         bready_i,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic [2:0]   arprot_i,
  input  wire logic         arvalid_i,
  output logic              arready_o,
  // AXI4-Lite read data
  output logic [31:0]       rdata_o,
  output logic [1:0]        rresp_o,
  output logic              rvalid_o,
  input  wire logic         rready_i
);

  // the map uses offsets up to 0x3C
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
    $error("flash_sec: ADDR_W must lie between 6 and 32");
  end

  // write channel holding registers
  logic              aw_full_q, aw_full_d;
  logic              w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q;
  bus_origin_t       aw_origin_q;
  logic [7:0]        w_byte_q;
  logic              w_lane0_q;
  logic              awready_q, awready_d;
  logic              wready_q, wready_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q;
  // read channel registers
  logic              arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  // security state
  logic              load_q;
  logic [7:0]        opt_shadow_q;
  logic [7:0]        nv_prot_shadow_q;
  logic [63:0]       key_store_q;
  logic [7:0]        prot_q;
  logic [1:0]        sec_field_q;
  logic              blank_unsec_q;
  logic              key_mode_q;
  logic              dbg_en_q;
  logic              secured_q;
  logic              grant_q;
  logic              locked_q;
  // key entry
  key_state_t        key_state_q;
  logic [3:0]        key_cnt_q;
  logic              key_bad_q;
  logic [7:0]        key_buf_q [8];
  logic [7:0]        byte_match;

  // channel handshakes
  wire aw_take  = awvalid_i & awready_q;
  wire w_take   = wvalid_i & wready_q;
  wire wr_fire  = aw_full_q & w_full_q & ~bvalid_q;
  wire ar_take  = arvalid_i & arready_q;

  // write decode, registers are byte wide so only lane 0 carries data
  wire [ADDR_W-1:0] wa = aw_addr_q;
  wire hit_cfg    = wa == ADDR_W'(`FSEC_CFG_OFF);
  wire hit_prot   = wa == ADDR_W'(`FSEC_PROT_OFF);
  wire hit_dbg    = wa == ADDR_W'(`FSEC_DBG_OFF);
  wire hit_blank  = wa == ADDR_W'(`FSEC_BLANK_OFF);
  wire hit_key    = (wa >= ADDR_W'(`FSEC_KEY_BASE_OFF)) && (wa <= ADDR_W'(`FSEC_KEY_LAST_OFF)) && (wa[1:0] == 2'h0);
  wire hit_ro     = (wa == ADDR_W'(`FSEC_STATUS_OFF)) || (wa == ADDR_W'(`FSEC_OPT_OFF))
                    || (wa == ADDR_W'(`FSEC_NV_PROT_OFF));
  wire wr_mapped  = hit_cfg | hit_prot | hit_dbg | hit_blank | hit_key | hit_ro;
  wire wr_en      = wr_fire & w_lane0_q;
  wire [2:0] key_idx = 3'(wa[4:2]);

  // security decode
  wire key_path_en = opt_shadow_q[`FSEC_OPT_KEY_EN_BIT];
  wire secured_now = (sec_field_q != `FSEC_UNSECURE_CODE) & ~blank_unsec_q;
  wire vect_prot   = prot_q[`FSEC_PROT_VECT_BIT];
  wire key_mode_set = wr_en & hit_cfg & w_byte_q[`FSEC_CFG_KEY_MODE_BIT] & key_path_en
                     & aw_origin_q.secure_code & ~aw_origin_q.debug;
  wire key_mode_clr = wr_en & hit_cfg & ~w_byte_q[`FSEC_CFG_KEY_MODE_BIT] & key_mode_q;
  wire key_write   = wr_en & hit_key & key_mode_q & (key_state_q == KEY_COLLECT)
                     & aw_origin_q.secure_code & ~aw_origin_q.debug;
  wire key_in_order = (key_cnt_q < `FSEC_KEY_BYTES) && (4'(key_idx) == key_cnt_q);
  wire key_match   = (&byte_match) & (key_cnt_q == `FSEC_KEY_BYTES) & ~key_bad_q;
  wire unlock      = key_mode_clr & key_path_en & key_match;
  wire blank_go    = wr_en & hit_blank & w_byte_q[`FSEC_BLANK_GO_BIT] & aw_origin_q.debug;

  // per-byte comparison of the entered key with the stored key
  for (genvar i = 0; i < 8; i++) begin : g_key_cmp
    assign byte_match[i] = key_buf_q[i] == key_store_q[8*i +: 8];
  end

  // handshake next values; each ready drops once its channel is held
  assign aw_full_d = (aw_full_q & ~wr_fire) | aw_take;
  assign w_full_d  = (w_full_q & ~wr_fire) | w_take;
  assign bvalid_d  = (bvalid_q & ~bready_i) | wr_fire;
  assign awready_d = ~aw_full_d & ~load_q;
  assign wready_d  = ~w_full_d & ~load_q;
  assign rvalid_d  = (rvalid_q & ~rready_i) | ar_take;
  assign arready_d = ~rvalid_d & ~load_q;

  // read decode
  wire [ADDR_W-1:0] ra = araddr_i;
  wire [7:0] status_byte = {3'h0, dbg_en_q, key_mode_q, key_path_en, sec_field_q[1], secured_now};
  wire rd_key  = (ra >= ADDR_W'(`FSEC_KEY_BASE_OFF)) && (ra <= ADDR_W'(`FSEC_KEY_LAST_OFF)) && (ra[1:0] == 2'h0);
  wire [7:0] rd_byte =
      (ra == ADDR_W'(`FSEC_CFG_OFF))    ? {7'h00, key_mode_q} :
      (ra == ADDR_W'(`FSEC_STATUS_OFF)) ? status_byte :
      (ra == ADDR_W'(`FSEC_OPT_OFF))    ? opt_shadow_q :
      (ra == ADDR_W'(`FSEC_PROT_OFF))   ? prot_q :
      (ra == ADDR_W'(`FSEC_NV_PROT_OFF)) ? nv_prot_shadow_q :
      (ra == ADDR_W'(`FSEC_DBG_OFF))    ? {7'h00, dbg_en_q} :
      (ra == ADDR_W'(`FSEC_BLANK_OFF))  ? {7'h00, flash_blank_i} : 8'h00;
  wire rd_mapped = rd_key || (ra == ADDR_W'(`FSEC_CFG_OFF)) || (ra == ADDR_W'(`FSEC_STATUS_OFF))
                   || (ra == ADDR_W'(`FSEC_OPT_OFF)) || (ra == ADDR_W'(`FSEC_PROT_OFF))
                   || (ra == ADDR_W'(`FSEC_NV_PROT_OFF)) || (ra == ADDR_W'(`FSEC_DBG_OFF))
                   || (ra == ADDR_W'(`FSEC_BLANK_OFF));

  // write address and data capture, independent of arrival order
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_full_q   <= 1'b0;
      w_full_q    <= 1'b0;
      aw_addr_q   <= '0;
      aw_origin_q <= '0;
      w_byte_q    <= 8'h00;
      w_lane0_q   <= 1'b0;
      awready_q   <= 1'b0;
      wready_q    <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      if (aw_take) begin
        aw_addr_q   <= awaddr_i;
        aw_origin_q <= origin_i;
      end
      if (w_take) begin
        w_byte_q  <= wdata_i[7:0];
        w_lane0_q <= wstrb_i[0];
      end
    end
  end

  // write response; unmapped addresses answer slverr, ignored writes answer okay
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `FSEC_RESP_OKAY;
    end else begin
      bvalid_q <= bvalid_d;
      if (wr_fire) begin
        bresp_q <= wr_mapped ? `FSEC_RESP_OKAY : `FSEC_RESP_SLVERR;
      end
    end
  end

  // read channel, data registered one cycle after the address is taken
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `FSEC_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= {24'h00_0000, rd_byte};  // key locations read as zero
        rresp_q <= rd_mapped ? `FSEC_RESP_OKAY : `FSEC_RESP_SLVERR;
      end
    end
  end

  // nonvolatile image is caught on the first edge after reset release, never by the reset itself
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_q          <= 1'b1;
      opt_shadow_q    <= `FSEC_OPT_RST;
      nv_prot_shadow_q <= `FSEC_PROT_RST;
      key_store_q     <= 64'h0000_0000_0000_0000;
    end else if (load_q) begin
      load_q          <= 1'b0;
      opt_shadow_q    <= nv_i.opt;
      nv_prot_shadow_q <= nv_i.prot;
      key_store_q     <= nv_i.key;
    end
  end

  // security field: reloaded every reset, changed only by a matching backdoor key
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sec_field_q   <= 2'h3;  // secure until the option byte has been read
      blank_unsec_q <= 1'b0;
    end else if (load_q) begin
      sec_field_q   <= nv_i.opt[1:0];
      blank_unsec_q <= 1'b0;
    end else begin
      // the change lives only in this flop, so the stored image is untouched
      if (unlock) begin
        sec_field_q <= `FSEC_UNSECURE_CODE;
      end
      if (blank_go && flash_blank_i) begin
        blank_unsec_q <= 1'b1;
      end
    end
  end

  // block protect register: loaded from the image, written by debug commands only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prot_q <= `FSEC_PROT_RST;
    end else if (load_q) begin
      prot_q <= nv_i.prot;
    end else if (wr_en && hit_prot && aw_origin_q.debug) begin
      prot_q <= w_byte_q;
    end
  end

  // key access mode bit; a debug-only master cannot raise it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_mode_q <= 1'b0;
    end else if (load_q) begin
      key_mode_q <= 1'b0;
    end else if (key_mode_set) begin
      key_mode_q <= 1'b1;
    end else if (key_mode_clr || !key_path_en) begin
      key_mode_q <= 1'b0;
    end
  end

  // key collection; an out-of-order byte spoils the attempt instead of being realigned
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_state_q <= KEY_IDLE;
      key_cnt_q   <= 4'h0;
      key_bad_q   <= 1'b0;
    end else begin
      unique case (key_state_q)
        KEY_IDLE: begin
          if (key_mode_set) begin
            key_state_q <= KEY_COLLECT;
            key_cnt_q   <= 4'h0;
            key_bad_q   <= 1'b0;
          end
        end
        KEY_COLLECT: begin
          if (key_mode_clr || !key_path_en) begin
            key_state_q <= KEY_IDLE;
          end else if (key_write) begin
            key_cnt_q <= key_in_order ? key_cnt_q + 4'h1 : key_cnt_q;
            key_bad_q <= key_bad_q | ~key_in_order;
          end
        end
      endcase
    end
  end

  // candidate key bytes, one slot per key location
  for (genvar i = 0; i < 8; i++) begin : g_key_buf
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        key_buf_q[i] <= 8'h00;
      end else if (key_mode_set) begin
        key_buf_q[i] <= 8'h00;
      end else if (key_write && key_idx == 3'(i)) begin
        key_buf_q[i] <= w_byte_q;
      end
    end
  end

  // debug module enable, refused and forced off while secured
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbg_en_q <= 1'b0;
    end else if (secured_now || load_q) begin
      dbg_en_q <= 1'b0;
    end else if (wr_en && hit_dbg) begin
      dbg_en_q <= w_byte_q[`FSEC_DBG_EN_BIT];
    end
  end

  // registered outputs; grant lags the request by one cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      secured_q <= 1'b1;
      grant_q   <= 1'b0;
      locked_q  <= 1'b0;
    end else begin
      secured_q <= secured_now;
      grant_q   <= dbg_mem_i.req & ~load_q & (~secured_now | ~dbg_mem_i.target_secure);
      locked_q  <= vect_prot;
    end
  end

  assign awready_o          = awready_q;
  assign wready_o           = wready_q;
  assign bvalid_o           = bvalid_q;
  assign bresp_o            = bresp_q;
  assign arready_o          = arready_q;
  assign rvalid_o           = rvalid_q;
  assign rdata_o            = rdata_q;
  assign rresp_o            = rresp_q;
  assign secured_o          = secured_q;
  assign debug_module_en_o  = dbg_en_q;
  assign key_block_locked_o = locked_q;
  assign dbg_mem_grant_o    = grant_q;

  // prot fields are accepted for protocol completeness only
  wire unused_prot = ^{awprot_i, arprot_i, wdata_i[31:8], wstrb_i[3:1]};

endmodule : flash_sec
`default_nettype wire

//--- common/flash_sec_map.svh
// flash_sec_map.svh: register offsets, field positions, reset values and counts for the flash security block.
// assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef FLASH_SEC_MAP_SVH
`define FLASH_SEC_MAP_SVH

// register byte offsets
`define FSEC_CFG_OFF        8'h00
`define FSEC_STATUS_OFF     8'h04
`define FSEC_OPT_OFF        8'h08
`define FSEC_PROT_OFF       8'h0C
`define FSEC_NV_PROT_OFF    8'h10
`define FSEC_DBG_OFF        8'h14
`define FSEC_BLANK_OFF      8'h18
`define FSEC_KEY_BASE_OFF   8'h20
`define FSEC_KEY_LAST_OFF   8'h3C

// field positions
`define FSEC_CFG_KEY_MODE_BIT 0
`define FSEC_OPT_KEY_EN_BIT   7
`define FSEC_PROT_VECT_BIT    0
`define FSEC_DBG_EN_BIT       0
`define FSEC_BLANK_GO_BIT     0

// values and reset values
`define FSEC_UNSECURE_CODE  2'h2
`define FSEC_OPT_RST        8'h00
`define FSEC_PROT_RST       8'h00
`define FSEC_KEY_BYTES      4'h8
`define FSEC_RESP_OKAY      2'h0
`define FSEC_RESP_SLVERR    2'h2

`endif

//--- common/flash_sec_pkg.sv
// flash_sec_pkg: types shared by the flash security block and its bench.
// assumes the constants of flash_sec_map.svh are included where offsets are needed.
package flash_sec_pkg;

  // nonvolatile image presented by the flash array
  typedef struct packed {
    logic [7:0]  opt;   // nonvolatile_option_byte
    logic [7:0]  prot;  // nonvolatile_protect_byte
    logic [63:0] key;   // stored key, byte 0 in bits 7:0
  } nv_image_t;

  // origin of the bus master driving the current access
  typedef struct packed {
    logic debug;        // background debug controller
    logic secure_code;  // code running from secure RAM or flash
  } bus_origin_t;

  // debug memory access request and whether its target is secure
  typedef struct packed {
    logic req;
    logic target_secure;
  } dbg_mem_req_t;

  typedef enum logic [0:0] {
    KEY_IDLE,
    KEY_COLLECT
  } key_state_t;

endpackage : flash_sec_pkg

//--- dv/flash_sec_chk.sv
// flash_sec_chk: port-level assertions for the flash security block.
// assumes it is bound into every flash_sec instance and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_map.svh"

module flash_sec_chk
  import flash_sec_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  // image, debug path and state
  input wire nv_image_t         nv_i,
  input wire dbg_mem_req_t      dbg_mem_i,
  input wire logic              dbg_mem_grant_o,
  input wire logic              secured_o,
  input wire logic              debug_module_en_o,
  // bus
  input wire logic              bvalid_o,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic              arvalid_i,
  input wire logic              arready_o,
  input wire logic [31:0]       rdata_o,
  input wire logic [1:0]        rresp_o,
  input wire logic              rvalid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // edges since reset release, saturating; the nv load settles by the 3rd
  logic [2:0] up_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end

  property p_grant_open;
    dbg_mem_i.req && !dbg_mem_i.target_secure && up_q != 3'h0 |=> dbg_mem_grant_o;
  endproperty
  a_grant_open: assert property (p_grant_open) else $error("open target not granted");
  property p_grant_shut;
    // grant and secured_o both lag the same edge, so judge them together
    dbg_mem_i.req && dbg_mem_i.target_secure |=> secured_o ? !dbg_mem_grant_o : 1'b1;
  endproperty
  a_grant_shut: assert property (p_grant_shut) else $error("secure target granted");
  property p_dbg_en;
    secured_o && up_q == 3'h7 |-> !debug_module_en_o;
  endproperty
  a_dbg_en: assert property (p_dbg_en) else $error("debug module enabled while secured");
  property p_sticky;
    !secured_o |=> !secured_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("security returned without reset");
  property p_load;
    up_q == 3'h3 |-> secured_o == (nv_i.opt[1:0] != 2'h2);
  endproperty
  a_load: assert property (p_load) else $error("security not taken from option field");
  property p_fall;
    $fell(secured_o) && up_q == 3'h7 |-> bvalid_o || $past(bvalid_o);
  endproperty
  a_fall: assert property (p_fall) else $error("security dropped without a write");
  property p_slverr;
    arvalid_i && arready_o && araddr_i == 8'h1C |=> rvalid_o && rresp_o == `FSEC_RESP_SLVERR && rdata_o == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
  property p_status;
    arvalid_i && arready_o && araddr_i == `FSEC_STATUS_OFF |=> rvalid_o && rresp_o == 2'h0 && rdata_o[0] == secured_o;
  endproperty
  a_status: assert property (p_status) else $error("status bit differs from state");

  c_unlock: cover property ($fell(secured_o) && up_q == 3'h7);
  c_grant: cover property (dbg_mem_grant_o && secured_o);
  c_dben: cover property (debug_module_en_o);
endmodule : flash_sec_chk

bind flash_sec flash_sec_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .nv_i(nv_i), .dbg_mem_i(dbg_mem_i),
  .dbg_mem_grant_o(dbg_mem_grant_o), .secured_o(secured_o), .debug_module_en_o(debug_module_en_o),
  .bvalid_o(bvalid_o), .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
  .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o)
);
`default_nettype wire

//--- dv/flash_nv_model.sv
// flash_nv_model: nonvolatile option, protect and key image as the debug side leaves it.
// assumes the bench programs or erases only while the block is held in reset.
`timescale 1ns/1ps
`default_nettype none

module flash_nv_model
  import flash_sec_pkg::*;
#(
  parameter logic [63:0] KEY = 64'h0F1E2D3C4B5A6978
) (
  // clock
  input  wire logic       clk_i,
  // bench commands
  input  wire logic       prog_i,
  input  wire logic [7:0] opt_i,
  input  wire logic [7:0] prot_i,
  input  wire logic       erase_i,
  // image towards the block
  output var nv_image_t   nv_o,
  output logic            blank_o
);
  nv_image_t img_q;

  // option, protect and key sit in one block, so one protect covers the key
  always_ff @(posedge clk_i) begin
    if (erase_i) img_q <= '1; // mass erase from the debug side
    else if (prog_i) img_q <= '{opt: opt_i, prot: prot_i, key: KEY};
  end
  // only this image is modelled, the rest of the array is taken as erased
  assign blank_o = (img_q == '1);
  assign nv_o    = img_q;
endmodule : flash_nv_model
`default_nettype wire

//--- dv/flash_security_backdoor_unlock_tb_top.sv
// flash_security_backdoor_unlock_tb_top: directed bench for the flash security block.
// assumes the nv model above and the bound checker; bench tasks act as CPU and debug master.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_map.svh"

module flash_security_backdoor_unlock_tb_top
  import flash_sec_pkg::*;
;
  localparam logic [63:0] KEY = 64'h0F1E2D3C4B5A6978;
  localparam bus_origin_t APP = 2'h1;
  localparam bus_origin_t DBG = 2'h2;
  logic         clk_i = 1'h0;
  logic         arst_n_i = 1'h0;
  logic         prog = 1'h0, erase = 1'h0, blank, grant, secured, dben, locked;
  logic [7:0]   opt = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]  wdata = 32'h0, rdata;
  logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  bus_origin_t  org = 2'h0;
  dbg_mem_req_t dbg = 2'h0;
  nv_image_t    nv;
  int           bad_count = 0, samples_checked = 0;

  always #20 clk_i = ~clk_i;

  flash_nv_model #(.KEY(KEY)) u_nv (.clk_i(clk_i), .prog_i(prog), .opt_i(opt), .prot_i(8'h00),
    .erase_i(erase), .nv_o(nv), .blank_o(blank));
  flash_sec #(.ADDR_W(8)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .nv_i(nv), .flash_blank_i(blank),
    .origin_i(org), .dbg_mem_i(dbg), .dbg_mem_grant_o(grant), .secured_o(secured),
    .debug_module_en_o(dben), .key_block_locked_o(locked), .awaddr_i(awaddr), .awprot_i(3'h0),
    .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hF), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr),
    .arprot_i(3'h0), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
    .rvalid_o(rvalid), .rready_i(rready));

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // a write holds each channel until its own ready; origin stays with the request
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bus_origin_t o);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    org <= o;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid && n < 40);
    bready <= 1'h0;
    if (!bvalid) chk("write answer", 32'h1, 32'h0);
    if (!bvalid) test_done();
    chk("bresp", 32'h0, 32'(bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (!rvalid && n < 40);
    rready <= 1'h0;
    if (!rvalid) chk("read answer", 32'h1, 32'h0);
    if (!rvalid) test_done();
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, exp, d & m);
    chk("rresp", 32'h0, 32'(r));
  endtask : rchk

  // program or erase the image while reset is held, then give the load its edges
  task automatic boot(input logic [7:0] o, input logic er, input int cyc);
    @(posedge clk_i);
    arst_n_i <= 1'h0;
    opt <= o;
    prog <= !er;
    erase <= er;
    @(posedge clk_i);
    prog <= 1'h0;
    erase <= 1'h0;
    repeat (cyc) @(posedge clk_i);
    arst_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
  endtask : boot

  task automatic dbg_try(input logic ts, input logic exp);
    @(posedge clk_i);
    dbg <= '{req: 1'h1, target_secure: ts};
    repeat (2) @(posedge clk_i);
    chk("grant", 32'(exp), 32'(grant));
    dbg <= 2'h0;
  endtask : dbg_try

  // key bytes go in ascending order, each write several cycles apart
  task automatic key_in(input logic [63:0] k, input bus_origin_t o);
    wr(`FSEC_CFG_OFF, 8'h01, o);
    for (int i = 0; i < 8; i++) begin
      wr(8'(32'h20 + 4 * i), k[8 * i +: 8], o);
    end
    wr(`FSEC_CFG_OFF, 8'h00, o);
  endtask : key_in

  task automatic s_secured();
    logic [31:0] d;
    logic [1:0]  r;
    boot(8'h83, 1'h0, 20);
    rchk("secured", `FSEC_STATUS_OFF, 32'h1, 32'h1);
    rchk("option shadow", 8'h08, 32'hFF, 32'h83);
    rchk("protect shadow", 8'h10, 32'hFF, 32'h00);
    wr(8'h14, 8'h01, DBG);
    rchk("debug enable", `FSEC_STATUS_OFF, 32'h10, 32'h0);
    chk("debug pin", 32'h0, 32'(dben));
    dbg_try(1'h1, 1'h0);
    dbg_try(1'h0, 1'h1);
    rd(8'h1C, d, r);
    chk("unmapped resp", 32'(`FSEC_RESP_SLVERR), 32'(r));
    wr(8'h0C, 8'h01, APP);
    @(posedge clk_i);
    chk("locked by app", 32'h0, 32'(locked));
    wr(8'h0C, 8'h01, DBG);
    @(posedge clk_i);
    chk("locked by debug", 32'h1, 32'(locked));
  endtask : s_secured

  task automatic s_keys();
    key_in(KEY ^ 64'h0000000080000000, APP);
    rchk("wrong key", `FSEC_STATUS_OFF, 32'h1, 32'h1);
    key_in(KEY, DBG);
    rchk("debug key", `FSEC_STATUS_OFF, 32'h1, 32'h1);
    // right bytes in descending order must spoil the attempt
    wr(`FSEC_CFG_OFF, 8'h01, APP);
    for (int i = 7; i >= 0; i--) begin
      wr(8'(32'h20 + 4 * i), KEY[8 * i +: 8], APP);
    end
    wr(`FSEC_CFG_OFF, 8'h00, APP);
    rchk("order spoiled", `FSEC_STATUS_OFF, 32'h1, 32'h1);
    key_in(KEY, APP);
    rchk("right key", `FSEC_STATUS_OFF, 32'h1, 32'h0);
    chk("secured pin", 32'h0, 32'(secured));
    rchk("protect kept", 8'h0C, 32'h1, 32'h1);
    boot(8'h83, 1'h0, 2);
    rchk("resecured", `FSEC_STATUS_OFF, 32'h1, 32'h1);
  endtask : s_keys

  task automatic s_modes();
    boot(8'h03, 1'h0, 2);
    key_in(KEY, APP);
    rchk("key disabled", `FSEC_STATUS_OFF, 32'h1, 32'h1);
    boot(8'h82, 1'h0, 2);
    rchk("open option", `FSEC_STATUS_OFF, 32'h1, 32'h0);
    wr(8'h14, 8'h01, DBG);
    rchk("debug enable", `FSEC_STATUS_OFF, 32'h10, 32'h10);
    chk("debug pin", 32'h1, 32'(dben));
    dbg_try(1'h1, 1'h1);
  endtask : s_modes

  // the debug side erases, then blank checks; software may not
  task automatic s_blank();
    boot(8'h00, 1'h1, 2);
    rchk("erased secured", `FSEC_STATUS_OFF, 32'h1, 32'h1);
    wr(8'h18, 8'h01, APP);
    rchk("app blank check", `FSEC_STATUS_OFF, 32'h1, 32'h1);
    wr(8'h18, 8'h01, DBG);
    rchk("debug blank check", `FSEC_STATUS_OFF, 32'h1, 32'h0);
    chk("blank secured pin", 32'h0, 32'(secured));
    rchk("blank flag", 8'h18, 32'h1, 32'h1);
  endtask : s_blank

  initial begin
    s_secured();
    s_keys();
    s_modes();
    s_blank();
    test_done();
  end
endmodule : flash_security_backdoor_unlock_tb_top
`default_nettype wire
